/* File: design/ckcfg_pkg.sv */
// constants and carrier types for the clock generator configuration block
package ckcfg_pkg;
  localparam logic [7:0] ADDR_DRIVE_MODE = 8'h0d;
  localparam logic [7:0] ADDR_IDENT = 8'h0e;
  localparam int DRIVE_MSB = 7;
  localparam int DRIVE_LSB = 5;
  localparam int WMODE_BIT = 0;
  localparam int IDENT_MSB = 4;
  localparam logic [2:0] SLEW_NORMAL = 3'h5;
  localparam logic [2:0] SLEW_WIRELESS = 3'h7;
  localparam logic [7:0] DRIVE_MODE_RESET = 8'ha0;
  localparam logic [7:0] IDENT_RESET = 8'h00;
  // arbitrary neutral value for the programmed identification
  localparam logic [4:0] IDENT_DEFAULT = 5'h01;

  typedef struct packed {
    logic cpu_or_src;
    logic usb_rate;
    logic freq_sel_a;
    logic freq_sel_b;
    logic freq_sel_c;
  } ckcfg_strap_type;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ckcfg_req_type;
endpackage

/* File: design/ckcfg_top.sv */
// register and strap-latch logic of the clock generator configuration
`timescale 1ns/1ns
// Function
// [RQ1] bits 7:5 of register 0xd drive the free-running 33 MHz buffer, 000 strongest, 111 weakest.
// [RQ2] with wireless mode 0 every single-ended slew code defaults to 101.
// [RQ3] with wireless mode 1 every single-ended slew code defaults to 111.
// [RQ4] register 0xe bits 4:0 hold the programmed identification, bits 7:5 are reserved.
// [RQ5] the cpu-or-src strap is latched at power good: 0 gives SRC, 1 gives a third CPU output.
// [RQ6] the usb rate strap is latched at power good: 0 gives 48 MHz, 1 gives 12 MHz.
// [RQ7] frequency selects A and B, driven valid by the board, choose the CPU frequency.
// [RQ8] power good is a level strobe whose rising assertion latches every strap.
// [RQ9] frequency select C joins A and B in choosing the CPU frequency.
// [RQ10] latched straps hold until the next power good assertion.
module ckcfg_top
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // register port, one access per cycle
  input wire ckcfg_pkg::ckcfg_req_type i_req,
  input wire logic i_req_valid,
  // pins: power good and straps
  input wire logic i_power_good_strobe,
  input wire ckcfg_pkg::ckcfg_strap_type i_straps,
  // results
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [2:0] o_freerun33_drive,
  output logic [2:0] o_default_slew,
  output logic o_cpu_out_third_sel,
  output logic o_usb_12m_sel,
  output logic [2:0] o_cpu_freq_sel,
  output logic o_straps_valid
);
  localparam int SW = $bits(ckcfg_pkg::ckcfg_strap_type);

  logic [2:0] pg_sync_q;
  logic [SW-1:0] st_s1_q;
  logic [SW-1:0] st_s2_q;
  logic [SW-1:0] st_s3_q;
  logic pg_level_q;
  logic [7:0] drive_mode_q;
  logic [7:0] ident_q;
  logic pg_rise;
  ckcfg_pkg::ckcfg_strap_type strap_q;

  function automatic logic [2:0] slew_default(input logic wmode);
    slew_default = wmode ? ckcfg_pkg::SLEW_WIRELESS : ckcfg_pkg::SLEW_NORMAL;
  endfunction

  // pins cross into the clock domain through three stages
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      pg_sync_q <= 3'h0;
      st_s1_q <= '0;
      st_s2_q <= '0;
      st_s3_q <= '0;
    end
    else
    begin
      pg_sync_q <= {pg_sync_q[1:0], i_power_good_strobe};
      st_s1_q <= i_straps;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
    end
  end

  // power good level only changes once stages two and three agree
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
      pg_level_q <= 1'b0;
    else if (pg_sync_q[1] == pg_sync_q[2])
      pg_level_q <= pg_sync_q[2];
  end

  assign pg_rise = (pg_sync_q[1] == pg_sync_q[2]) && pg_sync_q[2] && !pg_level_q; // [RQ8]

  // straps latched only on assertion; shared pins turn into clocks afterwards
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      strap_q <= '0;
      o_straps_valid <= 1'b0;
    end
    else if (pg_rise)
    begin
      strap_q <= st_s3_q; // [RQ8] [RQ10]
      o_straps_valid <= 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      o_cpu_out_third_sel <= 1'b0;
      o_usb_12m_sel <= 1'b0;
      o_cpu_freq_sel <= 3'h0;
    end
    else
    begin
      o_cpu_out_third_sel <= strap_q.cpu_or_src; // [RQ5]
      o_usb_12m_sel <= strap_q.usb_rate; // [RQ6]
      o_cpu_freq_sel <= {strap_q.freq_sel_c, strap_q.freq_sel_b, strap_q.freq_sel_a}; // [RQ7] [RQ9]
    end
  end

  // configuration registers
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      drive_mode_q <= ckcfg_pkg::DRIVE_MODE_RESET;
      ident_q <= {3'h0, ckcfg_pkg::IDENT_DEFAULT};
    end
    else if (i_req_valid && i_req.we)
    begin
      if (i_req.addr == ckcfg_pkg::ADDR_DRIVE_MODE)
        drive_mode_q <= i_req.wdata;
      if (i_req.addr == ckcfg_pkg::ADDR_IDENT)
        ident_q <= i_req.wdata; // [RQ4]
    end
  end

  // outputs registered; slew default follows the mode bit one cycle later
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      o_freerun33_drive <= 3'h0;
      o_default_slew <= ckcfg_pkg::SLEW_NORMAL;
    end
    else
    begin
      o_freerun33_drive <= drive_mode_q[ckcfg_pkg::DRIVE_MSB:ckcfg_pkg::DRIVE_LSB]; // [RQ1]
      o_default_slew <= slew_default(drive_mode_q[ckcfg_pkg::WMODE_BIT]); // [RQ2] [RQ3]
    end
  end

  // reads answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_req_valid && !i_req.we;
      case (i_req.addr)
        ckcfg_pkg::ADDR_DRIVE_MODE: o_rdata <= drive_mode_q;
        ckcfg_pkg::ADDR_IDENT: o_rdata <= {3'h0, ident_q[ckcfg_pkg::IDENT_MSB:0]}; // [RQ4]
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  property p_slew_mode;
    @(posedge i_clock) disable iff (!i_resetn)
    1'b1 |=> o_default_slew == ($past(drive_mode_q[0]) ? 3'h7 : 3'h5);
  endproperty
  a_slew_mode: assert property (p_slew_mode) else $error("slew default wrong"); // [RQ2] [RQ3]

  property p_drive;
    @(posedge i_clock) disable iff (!i_resetn)
    1'b1 |=> o_freerun33_drive == $past(drive_mode_q[7:5]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive code wrong"); // [RQ1]

  property p_ident_rsv;
    @(posedge i_clock) disable iff (!i_resetn)
    o_rvalid && $past(i_req.addr) == ckcfg_pkg::ADDR_IDENT |-> o_rdata[7:5] == 3'h0;
  endproperty
  a_ident_rsv: assert property (p_ident_rsv) else $error("ident reserved bits set"); // [RQ4]

  property p_rvalid;
    @(posedge i_clock) disable iff (!i_resetn)
    i_req_valid && !i_req.we |=> o_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing"); // [RQ4]

  property p_valid_flag;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_rise |=> o_straps_valid;
  endproperty
  a_valid_flag: assert property (p_valid_flag) else $error("straps valid not set"); // [RQ8]

  property p_latch;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_rise |=> strap_q == $past(st_s3_q);
  endproperty
  a_latch: assert property (p_latch) else $error("strap not latched"); // [RQ8]

  property p_hold;
    @(posedge i_clock) disable iff (!i_resetn)
    !pg_rise |=> $stable(strap_q);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed without power good"); // [RQ10]

  property p_cpu_sel;
    @(posedge i_clock) disable iff (!i_resetn)
    pg_rise ##1 !pg_rise |=> o_cpu_out_third_sel == $past(strap_q.cpu_or_src);
  endproperty
  a_cpu_sel: assert property (p_cpu_sel) else $error("cpu select wrong"); // [RQ5]

  property p_usb_sel;
    @(posedge i_clock) disable iff (!i_resetn)
    1'b1 |=> o_usb_12m_sel == $past(strap_q.usb_rate);
  endproperty
  a_usb_sel: assert property (p_usb_sel) else $error("usb select wrong"); // [RQ6]

  property p_freq;
    @(posedge i_clock) disable iff (!i_resetn)
    1'b1 |=> o_cpu_freq_sel == {$past(strap_q.freq_sel_c), $past(strap_q.freq_sel_b),
      $past(strap_q.freq_sel_a)};
  endproperty
  a_freq: assert property (p_freq) else $error("cpu frequency select wrong"); // [RQ7] [RQ9]
endmodule // ckcfg_top

/* File: verif/ckcfg_board.sv */
// board model: strap pins and power-good strobe
`timescale 1ns/1ns
module ckcfg_board
(
  // clock
  input wire logic i_clock,
  // bench control
  input wire logic i_apply,
  input wire logic i_drift,
  input wire ckcfg_pkg::ckcfg_strap_type i_values,
  // pins
  output ckcfg_pkg::ckcfg_strap_type o_straps,
  output logic o_power_good_strobe
);
  logic [3:0] wait_q = 4'h0;
  initial o_straps = '0;
  initial o_power_good_strobe = 1'b0;
  always @(posedge i_clock)
  begin
    if (i_apply)
    begin
      o_power_good_strobe <= 1'b0;
      o_straps <= i_values;
      wait_q <= 4'h6;
    end
    else if (wait_q != 4'h0)
    begin
      wait_q <= wait_q - 4'h1;
      // straps settle for several cycles before the strobe rises
      o_power_good_strobe <= (wait_q == 4'h1);
    end
    else if (i_drift)
      o_straps <= ~o_straps;
  end
endmodule // ckcfg_board

/* File: verif/ckcfg_top_tb_top.sv */
// self-checking bench for the configuration block
`timescale 1ns/1ns
module ckcfg_top_tb_top;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  ckcfg_pkg::ckcfg_req_type req = '0;
  logic req_valid = 1'b0;
  logic apply = 1'b0;
  logic drift = 1'b0;
  ckcfg_pkg::ckcfg_strap_type values = '0;
  ckcfg_pkg::ckcfg_strap_type straps;
  logic pg;
  logic [7:0] rdata;
  logic rvalid;
  logic [2:0] drive;
  logic [2:0] slew;
  logic [2:0] fsel;
  logic third;
  logic usb12;
  logic svalid;
  int n_errors = 0;
  int num_checks = 0;
  always #4 i_clock = ~i_clock;
  ckcfg_top u_ckcfg_top (.i_clock(i_clock), .i_resetn(i_resetn), .i_req(req),
    .i_req_valid(req_valid), .i_power_good_strobe(pg), .i_straps(straps), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_freerun33_drive(drive), .o_default_slew(slew),
    .o_cpu_out_third_sel(third), .o_usb_12m_sel(usb12), .o_cpu_freq_sel(fsel),
    .o_straps_valid(svalid));
  ckcfg_board u_ckcfg_board (.i_clock(i_clock), .i_apply(apply), .i_drift(drift),
    .i_values(values), .o_straps(straps), .o_power_good_strobe(pg));
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic reg_access(input logic we, input logic [7:0] addr, input logic [7:0] d);
    @(negedge i_clock);
    req = '{we: we, addr: addr, wdata: d};
    req_valid = 1'b1;
    @(negedge i_clock);
    req_valid = 1'b0;
    // the read answer stands for one cycle only, so look at it right away
    if (!we)
    begin
      check8("rvalid", 8'h01, {7'h0, rvalid});
      check8("rdata", d, rdata);
    end
  endtask
  task automatic latch(input logic [4:0] v);
    logic [4:0] exp;
    exp = {v[4], v[3], v[0], v[1], v[2]};
    @(negedge i_clock);
    values = v;
    apply = 1'b1;
    @(negedge i_clock);
    apply = 1'b0;
    for (int n = 0; !(svalid === 1'b1 && {third, usb12, fsel} === exp); n++)
    begin
      if (n > 40)
      begin
        check8("strap_wait", 8'h01, 8'h00);
        close_out();
      end
      @(negedge i_clock);
    end
    check8("straps", {3'h0, exp}, {3'h0, third, usb12, fsel});
  endtask
  initial
  begin
    repeat (8) @(negedge i_clock);
    i_resetn = 1'b1;
    check8("straps_valid", 8'h00, {7'h0, svalid});
    reg_access(1'b0, 8'h0d, 8'ha0);
    reg_access(1'b0, 8'h0e, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      reg_access(1'b1, 8'h0d, {i[2:0], 4'h5, i[0]});
      repeat (2) @(posedge i_clock);
      #1;
      check8("drive", {5'h0, i[2:0]}, {5'h0, drive});
      check8("slew", i[0] ? 8'h07 : 8'h05, {5'h0, slew});
      reg_access(1'b0, 8'h0d, {i[2:0], 4'h5, i[0]});
    end
    reg_access(1'b1, 8'h0e, 8'hff);
    reg_access(1'b0, 8'h0e, 8'h1f);
    reg_access(1'b1, 8'h20, 8'h5a);
    reg_access(1'b0, 8'h20, 8'h00);
    latch(5'b10101);
    drift = 1'b1;
    repeat (9) @(negedge i_clock);
    drift = 1'b0;
    check8("held", 8'h15, {3'h0, third, usb12, fsel});
    latch(5'b01010);
    close_out();
  end
endmodule // ckcfg_top_tb_top
